// >>> hw/spc_spi_ctrl.sv
// Serial peripheral control block: role select, enable sync, standby, overflow
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Mode 0x2 selects slave, 0x3 master
// - Notify off: overflow flagged when read out
// - Notify on: overflow flagged at overflow moment
// - Notify bit acts at once, no busy
// - Slave standby without run: drop all reception
// - Master standby: clock stops after transfer ends
// - Slave run in standby: continue, wake on receive
// - Master run in standby: clock kept, any wake
// - Enable reads back at once; busy until done
// - Enable reads written state, not actual state
// - Enable stays writable while unit enabled
module spc_spi_ctrl #(
  parameter int MASTER_HALF = spc_pkg::MASTER_HALF_CYC
) (
  // System clock and reset
  input  wire logic                      i_clk,
  input  wire logic                      i_reset_n,
  // Avalon-MM register slave (byte address)
  input  wire logic [spc_pkg::ADDR_W-1:0] i_avs_address,
  input  wire logic                      i_avs_read,
  input  wire logic                      i_avs_write,
  input  wire logic [31:0]               i_avs_writedata,
  input  wire logic [3:0]                i_avs_byteenable,
  output logic      [31:0]               o_avs_readdata,
  output logic                           o_avs_waitrequest,
  // Power management
  input  wire logic                      i_standby,
  output logic                           o_clk_request,
  output logic                           o_wake,
  // Link, slave role (link clock domain)
  input  wire logic                      i_sck,
  input  wire logic                      i_ss_n,
  input  wire logic                      i_mosi,
  output logic                           o_miso,
  output logic                           o_miso_oe,
  // Link, master role
  input  wire logic                      i_miso,
  output logic                           o_sck,
  output logic                           o_sck_oe,
  output logic                           o_mosi,
  output logic                           o_mosi_oe,
  output logic                           o_ss_n
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [2:0]  mode_r;
  logic        enable_r;
  logic        active_r;
  logic        runstby_r;
  logic        notify_r;
  logic [3:0]  sync_cnt_r;
  logic        sync_busy_r;
  logic        overflow_r;
  logic [7:0]  rx_data_r [2];
  logic [1:0]  rx_tag_r;
  logic [1:0]  rx_cnt_r;
  logic        wait_r;
  logic [31:0] rdata_r;
  logic        drop_r;
  logic        wake_r;
  logic        clk_req_r;
  // Link domain
  logic [2:0]  sl_bit_r;
  logic [6:0]  sl_shift_r;
  logic [7:0]  sl_hold_r;
  logic        sl_tgl_r;
  logic        sl_miso_r;
  logic        sl_oe_r;
  // Crossings into the system domain
  logic [2:0]  tgl_sync_r;
  logic [1:0]  ss_sync_r;
  logic [1:0]  miso_sync_r;
  // Master shifter
  spc_pkg::spc_mst_state_t mst_state_r;
  logic [7:0]  mst_half_r;
  logic [2:0]  mst_bit_r;
  logic [7:0]  mst_tx_r;
  logic [7:0]  mst_rx_r;
  logic        mst_sck_r;
  logic        mst_done_r;

  logic        wr_go;
  logic        rd_go;
  logic        is_master;
  logic        is_slave;
  logic        sl_byte;
  logic        push;
  logic [7:0]  push_data;
  logic        pop;
  logic        mst_start;
  logic        standby_stop;

  function automatic logic hit(input logic [spc_pkg::ADDR_W-1:0] a, input logic [7:0] idx);
    hit = (a == {idx, 2'b00});
  endfunction

  assign wr_go        = i_avs_write && !wait_r;
  assign rd_go        = i_avs_read && !wait_r;
  assign is_master    = active_r && (mode_r == spc_pkg::MODE_SPI_MASTER);
  assign is_slave     = active_r && (mode_r == spc_pkg::MODE_SPI_SLAVE);
  assign standby_stop = i_standby && !runstby_r;
  assign sl_byte      = tgl_sync_r[2] ^ tgl_sync_r[1];
  assign push         = (sl_byte && is_slave && !drop_r) || mst_done_r;
  assign push_data    = mst_done_r ? mst_rx_r : sl_hold_r;
  assign pop          = rd_go && hit(i_avs_address, spc_pkg::IDX_DATA) && (rx_cnt_r != 2'd0);
  assign mst_start    = wr_go && hit(i_avs_address, spc_pkg::IDX_DATA) && is_master
                        && (mst_state_r == spc_pkg::MST_IDLE) && !standby_stop;

  // ---------------------------------------------------------------
  // Bus handshake: one wait cycle, then the answer
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      wait_r <= 1'b1;
    else
      wait_r <= !((i_avs_read || i_avs_write) && wait_r);
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      rdata_r <= 32'h0000_0000;
    else if (i_avs_read && wait_r)
    begin
      rdata_r <= 32'h0000_0000;
      if (hit(i_avs_address, spc_pkg::IDX_CONTROL_A))
      begin
        rdata_r[spc_pkg::CTLA_ENABLE_BIT]  <= enable_r;
        rdata_r[spc_pkg::CTLA_MODE_LSB +: 3] <= mode_r;
        rdata_r[spc_pkg::CTLA_RUNSTBY_BIT] <= runstby_r;
        rdata_r[spc_pkg::CTLA_NOTIFY_BIT]  <= notify_r;
      end
      else if (hit(i_avs_address, spc_pkg::IDX_STATUS))
      begin
        rdata_r[spc_pkg::STAT_RX_READY_BIT] <= (rx_cnt_r != 2'd0);
        rdata_r[spc_pkg::STAT_OVERFLOW_BIT] <= overflow_r;
        rdata_r[spc_pkg::STAT_MASTER_BUSY]  <= (mst_state_r != spc_pkg::MST_IDLE);
        rdata_r[spc_pkg::STAT_ACTIVE_BIT]   <= active_r;
      end
      else if (hit(i_avs_address, spc_pkg::IDX_SYNC_BUSY))
        rdata_r[spc_pkg::SYNC_ENABLE_BIT] <= sync_busy_r;
      else if (hit(i_avs_address, spc_pkg::IDX_DATA))
        rdata_r[7:0] <= rx_data_r[0];
    end
  end

  // ---------------------------------------------------------------
  // Control A
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      mode_r    <= spc_pkg::MODE_RESET;
      enable_r  <= spc_pkg::CTLA_RESET[spc_pkg::CTLA_ENABLE_BIT];
      runstby_r <= spc_pkg::CTLA_RESET[spc_pkg::CTLA_RUNSTBY_BIT];
      notify_r  <= spc_pkg::CTLA_RESET[spc_pkg::CTLA_NOTIFY_BIT];
    end
    else if (wr_go && hit(i_avs_address, spc_pkg::IDX_CONTROL_A))
    begin
      if (i_avs_byteenable[0])
      begin
        enable_r  <= i_avs_writedata[spc_pkg::CTLA_ENABLE_BIT];
        runstby_r <= i_avs_writedata[spc_pkg::CTLA_RUNSTBY_BIT];
        // Role may only change while fully disabled
        if (!enable_r && !active_r && !sync_busy_r)
          mode_r <= i_avs_writedata[spc_pkg::CTLA_MODE_LSB +: 3];
      end
      if (i_avs_byteenable[1])
        notify_r <= i_avs_writedata[spc_pkg::CTLA_NOTIFY_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Enable synchronisation
  // ---------------------------------------------------------------
  // Busy rises on any enable write and falls once the core follows.
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      sync_busy_r <= 1'b0;
      sync_cnt_r  <= 4'h0;
      active_r    <= 1'b0;
    end
    else if (wr_go && hit(i_avs_address, spc_pkg::IDX_CONTROL_A) && i_avs_byteenable[0])
    begin
      sync_busy_r <= 1'b1;
      sync_cnt_r  <= spc_pkg::ENABLE_SYNC_CYC;
    end
    else if (sync_busy_r)
    begin
      if (sync_cnt_r == 4'h1)
      begin
        active_r    <= enable_r;
        sync_busy_r <= 1'b0;
      end
      sync_cnt_r <= sync_cnt_r - 4'h1;
    end
  end

  // ---------------------------------------------------------------
  // Slave standby drop
  // ---------------------------------------------------------------
  // Held until the link frame ends, so a frame cut by standby is lost whole.
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      drop_r <= 1'b0;
    else if (is_slave && standby_stop)
      drop_r <= 1'b1;
    else if (ss_sync_r[1] || !is_slave)
      drop_r <= 1'b0;
  end

  // ---------------------------------------------------------------
  // Receive buffer, two levels, with overflow marks
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rx_cnt_r     <= 2'd0;
      rx_tag_r     <= 2'b00;
      rx_data_r[0] <= 8'h00;
      rx_data_r[1] <= 8'h00;
    end
    else if (!active_r)
    begin
      rx_cnt_r <= 2'd0;
      rx_tag_r <= 2'b00;
    end
    else
    begin
      if (pop)
      begin
        rx_data_r[0] <= rx_data_r[1];
        rx_tag_r     <= {1'b0, rx_tag_r[1]};
      end
      if (push && rx_cnt_r == 2'd2 && !pop)
        rx_tag_r[1] <= 1'b1;
      else if (push && (rx_cnt_r - {1'b0, pop}) == 2'd0)
        rx_data_r[0] <= push_data;
      else if (push)
        rx_data_r[1] <= push_data;
      if (push && !pop && rx_cnt_r != 2'd2)
        rx_cnt_r <= rx_cnt_r + 2'd1;
      else if (pop && !push)
        rx_cnt_r <= rx_cnt_r - 2'd1;
    end
  end

  // Hardware set wins over the write-one clear.
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      overflow_r <= 1'b0;
    else if (!active_r)
      overflow_r <= 1'b0;
    else if (notify_r && push && rx_cnt_r == 2'd2 && !pop)
      overflow_r <= 1'b1;
    else if (!notify_r && pop && rx_tag_r[0])
      overflow_r <= 1'b1;
    else if (wr_go && hit(i_avs_address, spc_pkg::IDX_STATUS) && i_avs_byteenable[0]
             && i_avs_writedata[spc_pkg::STAT_OVERFLOW_BIT])
      overflow_r <= 1'b0;
  end

  // ---------------------------------------------------------------
  // Standby clock request and wake
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      clk_req_r <= 1'b0;
      wake_r    <= 1'b0;
    end
    else
    begin
      clk_req_r <= active_r && (!i_standby || runstby_r
                   || (is_master && mst_state_r != spc_pkg::MST_IDLE));
      wake_r    <= i_standby && ((is_master && (push || overflow_r))
                   || (is_slave && runstby_r && push));
    end
  end

  // ---------------------------------------------------------------
  // Crossings from the link
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      tgl_sync_r  <= 3'b000;
      ss_sync_r   <= 2'b11;
      miso_sync_r <= 2'b00;
    end
    else
    begin
      tgl_sync_r  <= {tgl_sync_r[1:0], sl_tgl_r};
      ss_sync_r   <= {ss_sync_r[0], i_ss_n};
      miso_sync_r <= {miso_sync_r[0], i_miso};
    end
  end

  // ---------------------------------------------------------------
  // Slave shifter on the link clock
  // ---------------------------------------------------------------
  // Bit position is cleared by the frame's select, so a stalled clock
  // between frames leaves no partial byte behind.
  always_ff @(posedge i_sck or negedge i_reset_n or posedge i_ss_n)
  begin
    if (!i_reset_n || i_ss_n)
    begin
      sl_bit_r   <= 3'd0;
      sl_shift_r <= 7'h00;
      sl_miso_r  <= 1'b0;
    end
    else
    begin
      sl_bit_r   <= sl_bit_r + 3'd1;
      sl_shift_r <= {sl_shift_r[5:0], i_mosi};
      sl_miso_r  <= sl_shift_r[6];
    end
  end

  // Held byte stays put for eight link clocks, far longer than the sync.
  always_ff @(posedge i_sck or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      sl_hold_r <= 8'h00;
      sl_tgl_r  <= 1'b0;
    end
    else if (!i_ss_n && sl_bit_r == 3'(spc_pkg::FRAME_BITS - 1))
    begin
      sl_hold_r <= {sl_shift_r, i_mosi};
      sl_tgl_r  <= ~sl_tgl_r;
    end
  end

  always_ff @(posedge i_sck or negedge i_reset_n or posedge i_ss_n)
  begin
    if (!i_reset_n || i_ss_n)
      sl_oe_r <= 1'b0;
    else
      sl_oe_r <= 1'b1;
  end

  // ---------------------------------------------------------------
  // Master shifter, mode 0, clock divided from the system clock
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      mst_state_r <= spc_pkg::MST_IDLE;
      mst_half_r  <= 8'h00;
      mst_bit_r   <= 3'd0;
      mst_tx_r    <= 8'h00;
      mst_rx_r    <= 8'h00;
      mst_sck_r   <= 1'b0;
      mst_done_r  <= 1'b0;
    end
    else
    begin
      mst_done_r <= 1'b0;
      case (mst_state_r)
        spc_pkg::MST_IDLE:
        begin
          mst_sck_r <= 1'b0;
          if (mst_start)
          begin
            mst_tx_r    <= i_avs_writedata[7:0];
            mst_bit_r   <= 3'd0;
            mst_half_r  <= 8'(MASTER_HALF - 1);
            mst_state_r <= spc_pkg::MST_LOW;
          end
        end
        spc_pkg::MST_LOW:
        begin
          if (mst_half_r == 8'h00)
          begin
            mst_sck_r   <= 1'b1;
            mst_half_r  <= 8'(MASTER_HALF - 1);
            mst_state_r <= spc_pkg::MST_HIGH;
          end
          else
            mst_half_r <= mst_half_r - 8'h01;
        end
        spc_pkg::MST_HIGH:
        begin
          if (mst_half_r == 8'h00)
          begin
            // Sample late in the high phase to absorb the input sync delay
            mst_rx_r   <= {mst_rx_r[6:0], miso_sync_r[1]};
            mst_tx_r   <= {mst_tx_r[6:0], 1'b0};
            mst_sck_r  <= 1'b0;
            mst_half_r <= 8'(MASTER_HALF - 1);
            mst_bit_r  <= mst_bit_r + 3'd1;
            if (mst_bit_r == 3'(spc_pkg::FRAME_BITS - 1))
            begin
              mst_done_r  <= 1'b1;
              mst_state_r <= spc_pkg::MST_IDLE;
            end
            else
              mst_state_r <= spc_pkg::MST_LOW;
          end
          else
            mst_half_r <= mst_half_r - 8'h01;
        end
        default:
          mst_state_r <= spc_pkg::MST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Pin drivers
  // ---------------------------------------------------------------
  logic mst_oe_r;
  logic mst_ss_n_r;

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      mst_oe_r   <= 1'b0;
      mst_ss_n_r <= 1'b1;
    end
    else
    begin
      mst_oe_r   <= is_master;
      mst_ss_n_r <= !(mst_start || (mst_state_r != spc_pkg::MST_IDLE && !mst_done_r));
    end
  end

  assign o_avs_readdata    = rdata_r;
  assign o_avs_waitrequest = wait_r;
  assign o_clk_request     = clk_req_r;
  assign o_wake            = wake_r;
  assign o_miso            = sl_miso_r;
  assign o_miso_oe         = sl_oe_r;
  assign o_sck             = mst_sck_r;
  assign o_sck_oe          = mst_oe_r;
  assign o_mosi            = mst_tx_r[7];
  assign o_mosi_oe         = mst_oe_r;
  assign o_ss_n            = mst_ss_n_r;

endmodule

`default_nettype wire

// >>> hw/spc_pkg.sv
// Constants shared by the serial peripheral control block
package spc_pkg;

  // ---------------------------------------------------------------
  // Register indices and byte addresses (byte address = 4 * index)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_CONTROL_A  = 8'h00;
  localparam logic [7:0] IDX_STATUS     = 8'h1a;
  localparam logic [7:0] IDX_SYNC_BUSY  = 8'h1c;
  localparam logic [7:0] IDX_DATA       = 8'h28;
  localparam int         ADDR_W         = 10;

  // ---------------------------------------------------------------
  // Control A field positions and reset value
  // ---------------------------------------------------------------
  localparam int          CTLA_ENABLE_BIT  = 1;
  localparam int          CTLA_MODE_LSB    = 2;
  localparam int          CTLA_RUNSTBY_BIT = 7;
  localparam int          CTLA_NOTIFY_BIT  = 8;
  localparam logic [31:0] CTLA_RESET       = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Operating modes
  // ---------------------------------------------------------------
  localparam logic [2:0] MODE_SPI_SLAVE  = 3'h2;
  localparam logic [2:0] MODE_SPI_MASTER = 3'h3;
  localparam logic [2:0] MODE_RESET      = 3'h0;

  // ---------------------------------------------------------------
  // Status and sync busy fields
  // ---------------------------------------------------------------
  localparam int STAT_RX_READY_BIT = 0;
  localparam int STAT_OVERFLOW_BIT = 2;
  localparam int STAT_MASTER_BUSY  = 4;
  localparam int STAT_ACTIVE_BIT   = 5;
  localparam int SYNC_ENABLE_BIT   = 1;

  // ---------------------------------------------------------------
  // Timing: enable synchronisation delay and master half bit
  // ---------------------------------------------------------------
  localparam int         CLK_MHZ          = 200;
  localparam int         ENABLE_SYNC_NS   = 15;
  localparam logic [3:0] ENABLE_SYNC_CYC  = 4'((ENABLE_SYNC_NS * CLK_MHZ + 999) / 1000);
  localparam int         MASTER_HALF_CYC  = 4;
  localparam int         FRAME_BITS       = 8;

  typedef enum logic [1:0] {
    MST_IDLE  = 2'b00,
    MST_LOW   = 2'b01,
    MST_HIGH  = 2'b10
  } spc_mst_state_t;

endpackage

// >>> dv/spc_spi_checker.sv
// Concurrent checks on the serial peripheral control block ports
`timescale 1ns/100ps
`default_nettype none
module spc_spi_checker (
  // Clock and reset
  input wire logic                        i_clk,
  input wire logic                        i_reset_n,
  // Register bus
  input wire logic [spc_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic                        i_avs_read,
  input wire logic                        i_avs_write,
  input wire logic [31:0]                 i_avs_writedata,
  input wire logic [3:0]                  i_avs_byteenable,
  input wire logic [31:0]                 o_avs_readdata,
  input wire logic                        o_avs_waitrequest,
  // Power and master pins
  input wire logic                        i_standby,
  input wire logic                        o_clk_request,
  input wire logic                        o_wake,
  input wire logic                        o_sck,
  input wire logic                        o_sck_oe,
  input wire logic                        o_ss_n
);
  // ----------------------------
  // Shadows of written control bits
  // ----------------------------
  logic       en_r;
  logic       run_r;
  logic       ntf_r;
  logic [3:0] rise_r;
  wire logic  ctl_wr = i_avs_write && !o_avs_waitrequest && i_avs_address == '0;

  always_ff @(posedge i_clk or negedge i_reset_n)
    if (!i_reset_n)
    begin
      en_r  <= 1'b0;
      run_r <= 1'b0;
      ntf_r <= 1'b0;
    end
    else if (ctl_wr)
    begin
      if (i_avs_byteenable[0])
      begin
        en_r  <= i_avs_writedata[1];
        run_r <= i_avs_writedata[7];
      end
      if (i_avs_byteenable[1])
        ntf_r <= i_avs_writedata[8];
    end

  // Clock rises seen within one select low period
  always_ff @(posedge i_clk or negedge i_reset_n)
    if (!i_reset_n)
      rise_r <= 4'h0;
    else if (o_ss_n)
      rise_r <= 4'h0;
    else if ($rose(o_sck))
      rise_r <= rise_r + 4'h1;

  // ----------------------------
  // Properties
  // ----------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  sequence ctl_rd_s;
    i_avs_read && !o_avs_waitrequest && i_avs_address == '0;
  endsequence

  wait_one_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("no answer after one wait");
  wait_pulse_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("long waitrequest low");
  en_back_a: assert property (ctl_rd_s |-> o_avs_readdata[1] == en_r)
    else $error("enable readback wrong");
  ntf_back_a: assert property (ctl_rd_s |-> o_avs_readdata[8] == ntf_r)
    else $error("notify readback wrong");
  mst_pins_a: assert property ($fell(o_ss_n) |-> o_sck_oe)
    else $error("master pins not driven");
  frame_len_a: assert property ($rose(o_ss_n) |-> rise_r == 4'h8)
    else $error("frame not eight clocks");
  hold_clk_a: assert property (!o_ss_n [*2] |-> o_clk_request)
    else $error("clock request dropped");
  stop_clk_a: assert property (i_standby && !run_r && o_ss_n [*4] |-> !o_clk_request)
    else $error("clock request kept in standby");
  wake_cause_a: assert property (o_wake |-> $past(i_standby))
    else $error("wake outside standby");
endmodule

bind spc_spi_ctrl spc_spi_checker chk_u (
  .i_clk, .i_reset_n, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
  .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .i_standby,
  .o_clk_request, .o_wake, .o_sck, .o_sck_oe, .o_ss_n
);
`default_nettype wire

// >>> dv/spc_link_model.sv
// Far side of the link: external master and external slave
`timescale 1ns/100ps
`default_nettype none
module spc_link_model #(
  parameter logic [7:0] REPLY = 8'ha5
) (
  // Toward the block slave pins
  output logic       o_sck,
  output logic       o_ss_n,
  output logic       o_mosi,
  // Toward the block master pins
  input  wire logic  i_clk,
  input  wire logic  i_m_sck,
  input  wire logic  i_m_ss_n,
  input  wire logic  i_m_mosi,
  output logic       o_m_miso,
  output logic [7:0] o_rx
);
  logic [7:0] tx_r;
  logic       sck_q;

  initial
  begin
    o_sck = 1'b0;
    o_ss_n = 1'b1;
    o_mosi = 1'b0;
    o_m_miso = 1'b0;
    o_rx = 8'h00;
    sck_q = 1'b0;
  end

  // Clock stands still between frames; data line is inverted there
  task automatic send_byte(input logic [7:0] b, input int half);
    o_ss_n = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      o_mosi = b[i];
      #half o_sck = 1'b1;
      #half o_sck = 1'b0;
    end
    #half o_ss_n = 1'b1;
    o_mosi = ~o_mosi;
  endtask

  // Slave answer: MSB first, shifted after each falling clock
  always @(posedge i_clk)
  begin
    if (i_m_ss_n)
    begin
      tx_r <= REPLY;
      o_m_miso <= ~o_m_miso;
    end
    else
    begin
      o_m_miso <= tx_r[7];
      if (sck_q && !i_m_sck)
        tx_r <= {tx_r[6:0], 1'b0};
    end
    if (!i_m_ss_n && i_m_sck && !sck_q)
      o_rx <= {o_rx[6:0], i_m_mosi};
    sck_q <= i_m_sck;
  end
endmodule
`default_nettype wire

// >>> dv/spc_spi_ctrl_tb.sv
// Self-checking bench for the serial peripheral control block
`timescale 1ns/100ps
`default_nettype none
module spc_spi_ctrl_tb;
  localparam logic [9:0]  A_CTL = {spc_pkg::IDX_CONTROL_A, 2'b00};
  localparam logic [9:0]  A_STA = {spc_pkg::IDX_STATUS, 2'b00};
  localparam logic [9:0]  A_SYN = {spc_pkg::IDX_SYNC_BUSY, 2'b00};
  localparam logic [9:0]  A_DAT = {spc_pkg::IDX_DATA, 2'b00};
  localparam logic [31:0] ALL   = 32'hffff_ffff;
  localparam logic [31:0] M_RDY = 32'h1 << spc_pkg::STAT_RX_READY_BIT;
  localparam logic [31:0] M_OVF = 32'h1 << spc_pkg::STAT_OVERFLOW_BIT;
  localparam logic [31:0] M_ACT = 32'h1 << spc_pkg::STAT_ACTIVE_BIT;
  localparam logic [31:0] M_SYN = 32'h1 << spc_pkg::SYNC_ENABLE_BIT;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [9:0]  address = 10'h000;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  be = 4'h0;
  logic        standby = 1'b0;
  int          wakes = 0;
  int          w0 = 0;
  logic [31:0] rdata;
  logic        waitreq;
  logic        clk_req;
  logic        wake;
  logic        ssck;
  logic        sss_n;
  logic        smosi;
  logic        mmiso;
  logic        msck;
  logic        mmosi;
  logic        mss_n;
  logic [7:0]  mrx;
  int          errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  always #2.5 clk = ~clk;

  spc_spi_ctrl #(.MASTER_HALF(4)) dut_u (
    .i_clk(clk), .i_reset_n(rst_n), .i_avs_address(address), .i_avs_read(read),
    .i_avs_write(write), .i_avs_writedata(wdata), .i_avs_byteenable(be),
    .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .i_standby(standby),
    .o_clk_request(clk_req), .o_wake(wake), .i_sck(ssck), .i_ss_n(sss_n),
    .i_mosi(smosi), .o_miso(), .o_miso_oe(), .i_miso(mmiso), .o_sck(msck),
    .o_sck_oe(), .o_mosi(mmosi), .o_mosi_oe(), .o_ss_n(mss_n));

  spc_link_model link_u (
    .o_sck(ssck), .o_ss_n(sss_n), .o_mosi(smosi), .i_clk(clk), .i_m_sck(msck),
    .i_m_ss_n(mss_n), .i_m_mosi(mmosi), .o_m_miso(mmiso), .o_rx(mrx));

  always @(posedge clk)
    if (wake === 1'b1)
      wakes++;

  // ----------------------------
  // Bus and check tasks
  // ----------------------------
  task automatic final_report();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d,
                     input logic [3:0] b, output logic [31:0] q);
    int n = 0;
    address <= a;
    wdata <= d;
    be <= b;
    read <= !wr;
    write <= wr;
    @(posedge clk);
    while (waitreq !== 1'b0 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 20)
      errors++;
    q = rdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] b);
    logic [31:0] q;
    bus(1'b1, a, d, b, q);
  endtask

  task automatic rd_chk(input logic [9:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hf, q);
    check(q & m, e);
  endtask

  task automatic poll(input logic [9:0] a, input int bitn, input logic v);
    logic [31:0] q;
    int n = 0;
    do
    begin
      bus(1'b0, a, 32'h0, 4'hf, q);
      n++;
    end
    while (q[bitn] !== v && n < 200);
    if (q[bitn] !== v)
      errors++;
  endtask

  task automatic settle();
    poll(A_SYN, spc_pkg::SYNC_ENABLE_BIT, 1'b0);
  endtask

  // Half period of 3 ns gives the 6 ns link clock
  task automatic slv(input logic [7:0] b);
    link_u.send_byte(b, 3);
    @(posedge clk);
  endtask

  task automatic mst(input logic [7:0] b);
    wr(A_DAT, {24'h0, b}, 4'h1);
    poll(A_STA, spc_pkg::STAT_MASTER_BUSY, 1'b0);
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      errors++;
      final_report();
    end
  end

  // ----------------------------
  // Main sequence
  // ----------------------------
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd_chk(A_CTL, ALL, 32'h0);
    rd_chk(10'h3fc, ALL, 32'h0);
    wr(A_CTL, 32'h0000_0008, 4'h1);
    wr(A_CTL, 32'h0000_000a, 4'h1);
    rd_chk(A_SYN, M_SYN, M_SYN);
    rd_chk(A_CTL, ALL, 32'h0000_000a);
    settle();
    rd_chk(A_STA, M_ACT, M_ACT);
    wr(A_CTL, 32'h0000_000e, 4'h1);
    rd_chk(A_CTL, ALL, 32'h0000_000a);
    settle();
    slv(8'h3c);
    poll(A_STA, spc_pkg::STAT_RX_READY_BIT, 1'b1);
    rd_chk(A_DAT, 32'hff, 32'h3c);
    // Overflow with late notify, then immediate notify
    for (int n = 0; n < 2; n++)
    begin
      wr(A_CTL, 32'h0000_000a | (32'(n) << 8), 4'h2);
      rd_chk(A_SYN, M_SYN, 32'h0);
      slv(8'h81);
      slv(8'h42);
      slv(8'h24);
      repeat (8) @(posedge clk);
      rd_chk(A_STA, M_OVF, (n == 1) ? M_OVF : 32'h0);
      rd_chk(A_DAT, 32'hff, 32'h81);
      rd_chk(A_DAT, 32'hff, 32'h42);
      rd_chk(A_STA, M_OVF | M_RDY, M_OVF);
      wr(A_STA, M_OVF, 4'h1);
    end
    // Slave in standby, running then dropping
    wr(A_CTL, 32'h0000_018a, 4'h3);
    settle();
    standby <= 1'b1;
    w0 = wakes;
    slv(8'h77);
    poll(A_STA, spc_pkg::STAT_RX_READY_BIT, 1'b1);
    check({31'h0, wakes != w0}, 32'h1);
    rd_chk(A_DAT, 32'hff, 32'h77);
    wr(A_CTL, 32'h0000_010a, 4'h1);
    settle();
    w0 = wakes;
    slv(8'h55);
    repeat (8) @(posedge clk);
    rd_chk(A_STA, M_RDY, 32'h0);
    check({30'h0, wakes != w0, clk_req}, 32'h0);
    standby <= 1'b0;
    slv(8'h66);
    poll(A_STA, spc_pkg::STAT_RX_READY_BIT, 1'b1);
    rd_chk(A_DAT, 32'hff, 32'h66);
    // Master role, awake then in standby
    wr(A_CTL, 32'h0000_0108, 4'h1);
    settle();
    rd_chk(A_STA, M_ACT, 32'h0);
    wr(A_CTL, 32'h0000_010c, 4'h1);
    wr(A_CTL, 32'h0000_010e, 4'h1);
    settle();
    mst(8'h5a);
    check({24'h0, mrx}, 32'h5a);
    rd_chk(A_DAT, 32'hff, 32'ha5);
    w0 = wakes;
    wr(A_DAT, 32'h96, 4'h1);
    standby <= 1'b1;
    poll(A_STA, spc_pkg::STAT_MASTER_BUSY, 1'b0);
    check({30'h0, wakes != w0, clk_req}, 32'h2);
    check({24'h0, mrx}, 32'h96);
    wr(A_CTL, 32'h0000_018e, 4'h1);
    settle();
    check({31'h0, clk_req}, 32'h1);
    mst(8'h3d);
    check({24'h0, mrx}, 32'h3d);
    standby <= 1'b0;
    final_report();
  end
endmodule
`default_nettype wire
